/* File: rtl/dsb_pkg.sv */
package dsb_pkg;

    // array geometry
    localparam int ADDR_W    = 4;                // word address width
    localparam int DATA_W    = 36;               // data pin width
    localparam int MEM_DEPTH = 1 << ADDR_W;      // words held in flip-flops

    // burst addressing
    localparam logic [1:0] BURST_STEP = 2'h2;    // advance per continue
    localparam logic [1:0] BURST_OFS0 = 2'h0;    // offset of a loaded burst
    localparam logic       LOAD_LSB   = 1'h0;    // lsb forced at every load
    localparam logic       FALL_LSB   = 1'h1;    // lsb of a falling-edge beat

    // buffer geometry
    localparam int BUF_DEPTH = 2;                // entries in write buffer

    // operation held between rising link edges
    typedef enum logic [1:0] {
        OP_BANK_DESEL = 2'b00,                   // data and echo floated
        OP_DESEL      = 2'b01,                   // data floated, echo runs
        OP_WRITE      = 2'b10,                   // late write burst
        OP_READ       = 2'b11                    // pipelined read burst
    } dsb_op_t;

    // reset values
    localparam dsb_op_t         OP_RST   = OP_BANK_DESEL;
    localparam logic [DATA_W-1:0] DQ_RST = {DATA_W{1'b0}};

    // all pins from the controller, synchronised as one group
    typedef struct packed {
        logic              ck;                   // link clock
        logic              sel_n;                // sync_select_n
        logic              bank_a;               // bank_enable_a
        logic              bank_b;               // bank_enable_b
        logic              pol_a;                // bank_polarity_a
        logic              pol_b;                // bank_polarity_b
        logic              advance_load;                  // advance_load
        logic              wr_n;                 // write enable, low = write
        logic [ADDR_W-1:1] addr;                 // address without addr_lsb
        logic [DATA_W-1:0] dq;                   // data pins in
    } dsb_pins_t;

    // one write beat on its way into the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;                 // word address
        logic [DATA_W-1:0] data;                 // beat data
    } dsb_beat_t;

endpackage : dsb_pkg

/* File: rtl/dsb_skid_buf.sv */
`timescale 1ns/1ns
module dsb_skid_buf
    import dsb_pkg::*;
(
    input  wire logic      clk,                  // block clock
    input  wire logic      rst_b,                // sync reset, active low
    input  wire logic      in_valid,             // beat offered
    output logic           in_ready,             // room for a beat
    input  wire dsb_beat_t in_data,              // offered beat
    output logic           out_valid,            // beat available
    input  wire logic      out_ready,            // drain takes beat
    output dsb_beat_t      out_data              // oldest beat
);

    dsb_beat_t  store_reg [BUF_DEPTH];           // entry storage
    dsb_beat_t  store_next [BUF_DEPTH];          // next entry storage
    logic       wr_ptr_reg, wr_ptr_next;         // fill index
    logic       rd_ptr_reg, rd_ptr_next;         // drain index
    logic [1:0] count_reg, count_next;           // entries held
    logic       push, pop;                       // handshakes taken

    // honest full and empty flags
    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = store_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // next pointers, count and storage
    always_comb begin
        store_next  = store_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push) begin
            store_next[wr_ptr_reg] = in_data;
            wr_ptr_next            = ~wr_ptr_reg;
        end
        if (pop) begin
            rd_ptr_next = ~rd_ptr_reg;
        end
        if (push && !pop) begin
            count_next = count_reg + 2'h1;
        end else if (pop && !push) begin
            count_next = count_reg - 2'h1;
        end
    end

    // pointer registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // entry registers, data only
    always_ff @(posedge clk) begin
        store_reg <= store_next;
    end

endmodule : dsb_skid_buf

/* File: rtl/dsb_burst_ctrl.sv */
`timescale 1ns/1ns
module dsb_burst_ctrl
    import dsb_pkg::*;
(
    input  wire logic              REF_CLK_IN,        // block clock, 25 MHz
    input  wire logic              RST_B_IN,          // sync reset, low
    input  wire logic              LINK_CLK_IN,       // memory clock pin
    input  wire logic              SYNC_SELECT_N_IN,  // chip select, low
    input  wire logic              BANK_ENABLE_A_IN,  // bank enable a
    input  wire logic              BANK_ENABLE_B_IN,  // bank enable b
    input  wire logic              BANK_POLARITY_A_IN,// sense of enable a
    input  wire logic              BANK_POLARITY_B_IN,// sense of enable b
    input  wire logic              ADVANCE_LOAD_IN,   // high = continue
    input  wire logic              WRITE_N_IN,        // low = write
    input  wire logic [ADDR_W-1:1] ADDR_IN,           // word address
    input  wire logic [DATA_W-1:0] DQ_IN,             // data pins in
    output logic      [DATA_W-1:0] DQ_OUT,            // data pins out
    output logic                   DQ_OE_OUT,         // data pins driven
    output logic                   ECHO_CLOCK_OUT,    // true echo clock
    output logic                   ECHO_CLOCK_N_OUT,  // inverted echo
    output logic                   ECHO_CLOCK_OE_OUT  // echo pins driven
);

    // composite bank enable from enables and polarity straps
    function automatic logic bank_true(input dsb_pins_t p);
        bank_true = (p.bank_a == p.pol_a) && (p.bank_b == p.pol_b);
    endfunction : bank_true

    // word address of a burst beat, wrapping inside four words
    function automatic logic [ADDR_W-1:0] beat_addr(
        input logic [ADDR_W-1:0] base,
        input logic [1:0]        ofs
    );
        logic [1:0] low;
        low       = base[1:0] + ofs;
        beat_addr = {base[ADDR_W-1:2], low};
    endfunction : beat_addr

    dsb_pins_t         pins_now;                 // raw pin group
    dsb_pins_t         pins_s1_reg;              // first sync stage
    dsb_pins_t         pins_s2_reg;              // second sync stage
    logic              ck_prev_reg;              // link clock one cycle ago
    logic              rise, fall;               // link clock edges

    dsb_op_t           op_reg, op_next;          // command being loaded
    logic [ADDR_W-1:0] base_reg, base_next;      // loaded base address
    logic [1:0]        ofs_reg, ofs_next;        // burst offset
    dsb_op_t           phase_reg, phase_next;    // operation on the pins
    logic [ADDR_W-1:0] paddr_reg, paddr_next;    // rise beat address
    logic [DATA_W-1:0] dq_reg, dq_next;          // read data out
    logic              dq_oe_reg, dq_oe_next;    // data drive
    logic              echo_reg, echo_next;      // echo level
    logic              echo_n_reg, echo_n_next;  // inverted echo level
    logic              eoe_reg, eoe_next;        // echo drive
    logic              cap_v_reg, cap_v_next;    // captured beat pending
    dsb_beat_t         cap_reg, cap_next;        // captured write beat

    logic [DATA_W-1:0] mem_reg [MEM_DEPTH];      // storage array
    logic [DATA_W-1:0] mem_next [MEM_DEPTH];     // next storage array

    logic              buf_in_ready;             // buffer accepts beat
    logic              buf_out_valid;            // buffer holds beat
    logic              drain_ready;              // array write port free
    dsb_beat_t         buf_out;                  // oldest buffered beat

    // gather the pins into one group
    assign pins_now = '{ck: LINK_CLK_IN, sel_n: SYNC_SELECT_N_IN,
                        bank_a: BANK_ENABLE_A_IN, bank_b: BANK_ENABLE_B_IN,
                        pol_a: BANK_POLARITY_A_IN,
                        pol_b: BANK_POLARITY_B_IN,
                        advance_load: ADVANCE_LOAD_IN, wr_n: WRITE_N_IN,
                        addr: ADDR_IN, dq: DQ_IN};

    // edges seen on the second sync stage only
    assign rise = pins_s2_reg.ck & ~ck_prev_reg;
    assign fall = ~pins_s2_reg.ck & ck_prev_reg;

    // the array port reads on edges, so the drain waits then
    assign drain_ready = ~(rise | fall);

    // two-entry buffer between beat capture and the array
    dsb_skid_buf u_wbuf (
        .clk       (REF_CLK_IN),
        .rst_b     (RST_B_IN),
        .in_valid  (cap_v_reg),
        .in_ready  (buf_in_ready),
        .in_data   (cap_reg),
        .out_valid (buf_out_valid),
        .out_ready (drain_ready),
        .out_data  (buf_out)
    );

    // command decode, burst counter and pin state
    always_comb begin
        op_next     = op_reg;
        base_next   = base_reg;
        ofs_next    = ofs_reg;
        phase_next  = phase_reg;
        paddr_next  = paddr_reg;
        dq_next     = dq_reg;
        dq_oe_next  = dq_oe_reg;
        echo_next   = echo_reg;
        echo_n_next = echo_n_reg;
        eoe_next    = eoe_reg;
        cap_v_next  = cap_v_reg;
        cap_next    = cap_reg;
        // a beat taken by the buffer leaves the capture slot
        if (cap_v_reg && buf_in_ready) begin
            cap_v_next = 1'b0;
        end
        if (rise) begin
            // the operation sampled last rise reaches the pins now
            phase_next  = op_reg;
            paddr_next  = beat_addr(base_reg, ofs_reg);
            dq_oe_next  = (op_reg == OP_READ);
            eoe_next    = (op_reg != OP_BANK_DESEL);
            echo_next   = 1'b1;
            echo_n_next = 1'b0;
            if (op_reg == OP_READ) begin
                // first beat of the pair on the rising edge
                dq_next = mem_reg[beat_addr(base_reg, ofs_reg)];
            end
            if (op_reg == OP_WRITE) begin
                // first write beat captured on the rising edge
                cap_v_next    = 1'b1;
                cap_next.addr = beat_addr(base_reg, ofs_reg);
                cap_next.data = pins_s2_reg.dq;
            end
            if (!pins_s2_reg.advance_load) begin
                // load: decode a new command
                base_next = {pins_s2_reg.addr, LOAD_LSB};
                ofs_next  = BURST_OFS0;
                if (!bank_true(pins_s2_reg)) begin
                    op_next = OP_BANK_DESEL;
                end else if (pins_s2_reg.sel_n) begin
                    op_next = OP_DESEL;
                end else if (!pins_s2_reg.wr_n) begin
                    op_next = OP_WRITE;
                end else begin
                    op_next = OP_READ;
                end
            end else if (op_reg == OP_READ || op_reg == OP_WRITE) begin
                // continue: step by two, second step wraps to base
                ofs_next = ofs_reg + BURST_STEP;
            end
        end
        if (fall) begin
            // second beat of the pair on the falling edge
            echo_next   = 1'b0;
            echo_n_next = 1'b1;
            if (phase_reg == OP_READ) begin
                dq_next = mem_reg[{paddr_reg[ADDR_W-1:1], FALL_LSB}];
            end
            if (phase_reg == OP_WRITE) begin
                cap_v_next    = 1'b1;
                cap_next.addr = {paddr_reg[ADDR_W-1:1], FALL_LSB};
                cap_next.data = pins_s2_reg.dq;
            end
        end
    end

    // array write from the buffer head
    always_comb begin
        mem_next = mem_reg;
        if (buf_out_valid && drain_ready) begin
            mem_next[buf_out.addr] = buf_out.data;
        end
    end

    // control and pin registers
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            pins_s1_reg <= '0;
            pins_s2_reg <= '0;
            ck_prev_reg <= 1'b0;
            op_reg      <= OP_RST;
            base_reg    <= '0;
            ofs_reg     <= BURST_OFS0;
            phase_reg   <= OP_RST;
            paddr_reg   <= '0;
            dq_reg      <= DQ_RST;
            dq_oe_reg   <= 1'b0;
            echo_reg    <= 1'b0;
            echo_n_reg  <= 1'b1;
            eoe_reg     <= 1'b0;
            cap_v_reg   <= 1'b0;
            cap_reg     <= '0;
        end else begin
            pins_s1_reg <= pins_now;
            pins_s2_reg <= pins_s1_reg;
            ck_prev_reg <= pins_s2_reg.ck;
            op_reg      <= op_next;
            base_reg    <= base_next;
            ofs_reg     <= ofs_next;
            phase_reg   <= phase_next;
            paddr_reg   <= paddr_next;
            dq_reg      <= dq_next;
            dq_oe_reg   <= dq_oe_next;
            echo_reg    <= echo_next;
            echo_n_reg  <= echo_n_next;
            eoe_reg     <= eoe_next;
            cap_v_reg   <= cap_v_next;
            cap_reg     <= cap_next;
        end
    end

    // storage array, no reset
    always_ff @(posedge REF_CLK_IN) begin
        mem_reg <= mem_next;
    end

    // outputs straight from flip-flops
    assign DQ_OUT            = dq_reg;
    assign DQ_OE_OUT         = dq_oe_reg;
    assign ECHO_CLOCK_OUT    = echo_reg;
    assign ECHO_CLOCK_N_OUT  = echo_n_reg;
    assign ECHO_CLOCK_OE_OUT = eoe_reg;

endmodule : dsb_burst_ctrl

/* File: tb/dsb_burst_ctrl_properties.sv */
`timescale 1ns/1ns
module dsb_burst_ctrl_chk
    import dsb_pkg::*;
(
    input wire logic              REF_CLK_IN,         // block clock
    input wire logic              RST_B_IN,           // reset, low
    input wire logic              LINK_CLK_IN,        // link clock
    input wire logic              SYNC_SELECT_N_IN,   // select, low
    input wire logic              BANK_ENABLE_A_IN,   // enable a
    input wire logic              BANK_ENABLE_B_IN,   // enable b
    input wire logic              BANK_POLARITY_A_IN, // sense a
    input wire logic              BANK_POLARITY_B_IN, // sense b
    input wire logic              ADVANCE_LOAD_IN,    // continue
    input wire logic              WRITE_N_IN,         // write, low
    input wire logic [ADDR_W-1:1] ADDR_IN,            // address
    input wire logic [DATA_W-1:0] DQ_IN,              // data in
    input wire logic [DATA_W-1:0] DQ_OUT,             // read data
    input wire logic              DQ_OE_OUT,          // data driven
    input wire logic              ECHO_CLOCK_OUT,     // true echo
    input wire logic              ECHO_CLOCK_N_OUT,   // inverted echo
    input wire logic              ECHO_CLOCK_OE_OUT   // echo driven
);
    logic    link_q_reg;  // link level at last edge
    logic    link_q_next; // next link level
    logic    bank_t;      // composite bank enable
    dsb_op_t op_reg;      // operation last loaded
    dsb_op_t op_next;     // next loaded operation
    dsb_op_t eff_reg;     // operation shown on the pins
    dsb_op_t eff_next;    // next shown operation

    // reference decode, stepped at every link rise seen on the pin
    always_comb begin
        link_q_next = LINK_CLK_IN;
        op_next     = op_reg;
        eff_next    = eff_reg;
        bank_t      = (BANK_ENABLE_A_IN == BANK_POLARITY_A_IN) &&
                      (BANK_ENABLE_B_IN == BANK_POLARITY_B_IN);
        if (LINK_CLK_IN && !link_q_reg) begin
            eff_next = op_reg;
            if (!ADVANCE_LOAD_IN) begin
                if (!bank_t) op_next = OP_BANK_DESEL;
                else if (SYNC_SELECT_N_IN) op_next = OP_DESEL;
                else if (WRITE_N_IN) op_next = OP_READ;
                else op_next = OP_WRITE;
            end
        end
    end

    // registers the reference state only
    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_B_IN) begin
            link_q_reg <= 1'b0;
            op_reg     <= OP_RST;
            eff_reg    <= OP_RST;
        end else begin
            link_q_reg <= link_q_next;
            op_reg     <= op_next;
            eff_reg    <= eff_next;
        end
    end

    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    AST_RESET_IDLE: assert property ($rose(RST_B_IN) |->
        !DQ_OE_OUT && !ECHO_CLOCK_OE_OUT && DQ_OUT == DQ_RST)
        else $error("outputs not idle after reset");
    AST_ECHO_PAIR: assert property (
        ECHO_CLOCK_N_OUT != ECHO_CLOCK_OUT)
        else $error("echo pair not complementary");
    AST_ECHO_RISE: assert property (
        $rose(LINK_CLK_IN) |-> ##[2:5] $rose(ECHO_CLOCK_OUT))
        else $error("echo clock missed a link rise");
    AST_ECHO_FALL: assert property (
        $fell(LINK_CLK_IN) |-> ##[2:5] $fell(ECHO_CLOCK_OUT))
        else $error("echo clock missed a link fall");
    AST_OE_AT_RISE: assert property (
        $changed(DQ_OE_OUT) || $changed(ECHO_CLOCK_OE_OUT)
        |-> $rose(ECHO_CLOCK_OUT))
        else $error("drive enable changed away from a rise");
    AST_DQ_OE: assert property ($rose(ECHO_CLOCK_OUT) |->
        DQ_OE_OUT == (eff_reg == OP_READ))
        else $error("data drive wrong for previous command");
    AST_ECHO_OE: assert property ($rose(ECHO_CLOCK_OUT) |->
        ECHO_CLOCK_OE_OUT == (eff_reg != OP_BANK_DESEL))
        else $error("echo drive wrong for previous command");
    AST_DQ_AT_EDGE: assert property (
        $changed(DQ_OUT) |-> $changed(ECHO_CLOCK_OUT))
        else $error("read data changed away from a link edge");
endmodule : dsb_burst_ctrl_chk

bind dsb_burst_ctrl dsb_burst_ctrl_chk u_chk (.REF_CLK_IN, .RST_B_IN,
    .LINK_CLK_IN, .SYNC_SELECT_N_IN, .BANK_ENABLE_A_IN, .BANK_ENABLE_B_IN,
    .BANK_POLARITY_A_IN, .BANK_POLARITY_B_IN, .ADVANCE_LOAD_IN,
    .WRITE_N_IN, .ADDR_IN, .DQ_IN, .DQ_OUT, .DQ_OE_OUT, .ECHO_CLOCK_OUT,
    .ECHO_CLOCK_N_OUT, .ECHO_CLOCK_OE_OUT);

/* File: tb/dsb_ctrl_model.sv */
`timescale 1ns/1ns
module dsb_ctrl_model
    import dsb_pkg::*;
(
    output dsb_pins_t              pins,   // pins toward the device
    input  wire logic [DATA_W-1:0] dq_out, // read data
    input  wire logic              dq_oe,  // device drives data
    input  wire logic              echo_oe // device drives echo
);
    logic [DATA_W-1:0] rise_q;    // rise beat seen at cycle start
    logic [DATA_W-1:0] fall_q;    // fall beat seen mid cycle
    logic              oe_q;      // data drive seen at cycle start
    logic              echo_oe_q; // echo drive seen at cycle start

    // link clock low and still until the first cycle
    initial pins = '0;

    // one link period: command steady 80 ns around the rise, write
    // beats steady around the edge that carries them
    task automatic cycle(input dsb_pins_t c, input logic beat,
                         input logic [DATA_W-1:0] fall_d);
        rise_q    = dq_out;
        oe_q      = dq_oe;
        echo_oe_q = echo_oe;
        c.ck      = 1'b0;
        if (!beat) c.dq = ~pins.dq;   // released: never the old value
        pins = c;
        #80 pins.ck = 1'b1;
        #80 fall_q = dq_out;
        pins.dq = beat ? fall_d : ~pins.dq;
        #80 pins.ck = 1'b0;
        #80;
    endtask : cycle
endmodule : dsb_ctrl_model

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
    import dsb_pkg::*;
    logic              ref_clk; // block clock
    logic              rst_b;   // block reset
    dsb_pins_t         pins;    // controller pins
    logic [DATA_W-1:0] dq_out;  // read data
    logic              dq_oe;   // data drive
    logic              echo;    // echo clock
    logic              echo_n;  // inverted echo
    logic              echo_oe; // echo drive
    logic [1:0]        pol;     // bank polarity pins
    int                errors;  // mismatches
    int                checked; // comparisons

    dsb_burst_ctrl i_dsb_burst_ctrl (.REF_CLK_IN(ref_clk), .RST_B_IN(rst_b),
        .LINK_CLK_IN(pins.ck), .SYNC_SELECT_N_IN(pins.sel_n),
        .BANK_ENABLE_A_IN(pins.bank_a), .BANK_ENABLE_B_IN(pins.bank_b),
        .BANK_POLARITY_A_IN(pins.pol_a), .BANK_POLARITY_B_IN(pins.pol_b),
        .ADVANCE_LOAD_IN(pins.advance_load), .WRITE_N_IN(pins.wr_n),
        .ADDR_IN(pins.addr), .DQ_IN(pins.dq), .DQ_OUT(dq_out),
        .DQ_OE_OUT(dq_oe), .ECHO_CLOCK_OUT(echo), .ECHO_CLOCK_N_OUT(echo_n),
        .ECHO_CLOCK_OE_OUT(echo_oe));
    dsb_ctrl_model u_ctrl (.pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
        .echo_oe(echo_oe));

    // 25 MHz block clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // compares one value and counts it
    task automatic check(input logic [DATA_W-1:0] seen, want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check

    // beat data that carries its own word address
    function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] w);
        pat = {32'h9e37_79b9, w};
    endfunction : pat

    // one link period with the given select, enables, advance, write
    task automatic op(input logic s, input logic [1:0] en, input logic v, w,
                      input logic [ADDR_W-1:1] a, input logic bt,
                      input logic [DATA_W-1:0] dr, df);
        u_ctrl.cycle({1'b0, s, en, pol, v, w, a, dr}, bt, df);
    endtask : op

    // write four beats, then read them back past the counter wrap
    task automatic t_burst(input logic [ADDR_W-1:1] a);
        logic [ADDR_W-1:0] k [4];
        int                i;
        for (i = 0; i < 4; i++) begin
            k[i] = {a[ADDR_W-1:2], 2'({a[1], LOAD_LSB} + i)};
        end
        op(1'b0, pol, 1'b0, 1'b0, a, 1'b0, '0, '0);
        op(1'b1, ~pol, 1'b1, 1'b1, ~a, 1'b1, pat(k[0]), pat(k[1]));
        op(1'b0, pol, 1'b0, 1'b1, a, 1'b1, pat(k[2]), pat(k[3]));
        check(DATA_W'(u_ctrl.oe_q), '0);
        // continue, continue, select deselect, continue
        for (i = 0; i < 4; i++) begin
            op(1'b1, (i == 2) ? pol : ~pol, i != 2, 1'b0, ~a, 1'b0, '0, '0);
            if (i > 0) begin
                check(u_ctrl.rise_q, pat(k[(i * 2 - 2) % 4]));
                check(u_ctrl.fall_q, pat(k[(i * 2 - 1) % 4]));
            end
        end
        $display("burst test done, errors %0d", errors);
    endtask : t_burst

    // bank deselect, deselect, write, read, each held by continues
    task automatic t_modes;
        int k;
        for (k = 0; k < 4; k++) begin
            op(k == 1, (k == 0) ? ~pol : pol, 1'b0, k != 2, 3'h5, 1'b0,
               '0, '0);
            op(1'b0, pol, 1'b1, 1'b0, 3'h2, 1'b0, '0, '0);
            repeat (2) begin
                op(1'b0, ~pol, 1'b1, 1'b0, 3'h2, 1'b0, '0, '0);
                check(DATA_W'(u_ctrl.oe_q), DATA_W'(k == 3));
                check(DATA_W'(u_ctrl.echo_oe_q), DATA_W'(k != 0));
            end
        end
        $display("mode test done, errors %0d", errors);
    endtask : t_modes

    // every polarity against every enable pattern
    task automatic t_bank;
        int p;
        int e;
        for (p = 0; p < 4; p++) begin
            for (e = 0; e < 4; e++) begin
                pol = 2'(p);
                op(1'b1, 2'(e), 1'b0, 1'b1, 3'h0, 1'b0, '0, '0);
                repeat (2) op(1'b1, 2'(e), 1'b1, 1'b1, 3'h0, 1'b0, '0, '0);
                check(DATA_W'(u_ctrl.echo_oe_q), DATA_W'(p == e));
                // echo keeps running with its drive off: high after a rise
                check(DATA_W'({echo, echo_n}), DATA_W'(2'h2));
            end
        end
        $display("bank test done, errors %0d", errors);
    endtask : t_bank

    // prints the counts and the verdict, then ends the run
    task automatic finish_test;
        $display("checked %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // main sequence; every pin moves 1 ns after a block clock edge
    initial begin
        errors  = 0;
        checked = 0;
        pol     = 2'b10;
        rst_b   = 1'b0;
        repeat (20) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        @(posedge ref_clk);
        #1 check(DATA_W'({dq_oe, echo_oe, echo_n}), DATA_W'(3'h1));
        t_burst(3'h1);
        t_burst(3'h6);
        t_modes();
        t_bank();
        finish_test();
    end

    // about eighty link periods of traffic fit well inside this span
    initial begin
        #60000;
        errors++;
        finish_test();
    end
endmodule : tb
